// ==== pwi_wake_irq.sv ====
// Per-port wake enables, wake flags and interrupt summary for the switch ports.
// Assumes a single core clock, synchronous inputs and a plain register port.
// Notes on behaviour
// - Magic packet asserts power event when enabled
// - Magic packet needs destination equal switch address
// - Link up asserts power event when enabled
// - Energy detect asserts power event when enabled
// - Link and energy wake only on PHY ports
// - SGMII autoneg done status bit3, port 7
// - PTP summary in bit2, PHY ports only
// - PHY summary in bit1, PHY ports only
// - ACL counter interrupt sets status bit0
// - ACL flag clears only on mask toggle
// - Mask bits active low, reset enabled
// - Status gated by mask forms interrupt
// - SGMII mask bit3 only on port 7
// - ACL status and mask on every port
// - PTP and PHY bits zero on MAC ports
// - Wake detections latched, cleared by writing one
`timescale 1ns/1ns
`include "pwi_defines.svh"

module pwi_wake_irq #(
    parameter int                       NUM_PORTS  = `PWI_NUM_PORTS,
    parameter logic [NUM_PORTS-1:0]     PHY_PORTS  = `PWI_PHY_PORTS,
    parameter int                       SGMII_PORT = `PWI_SGMII_PORT
) (
    input  wire logic                                  clock_i,
    input  wire logic                                  rst_i,
    input  wire pwi_pkg::pwi_bus_s                     bus_i,
    output pwi_pkg::pwi_byte_t                         rdata_o,
    input  wire logic [`PWI_MAC_W-1:0]                 switch_mac_i,
    input  wire pwi_pkg::pwi_port_in_s [NUM_PORTS-1:0] port_i,
    output logic                                       power_event_output_o,
    output logic                                       irq_o
);

    import pwi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // Port number must fit the address nibble; SGMII port must exist
    if (NUM_PORTS < 1 || NUM_PORTS > `PWI_MAX_PORTS) begin : g_bad_ports
        $error("pwi_wake_irq: NUM_PORTS out of range");
    end
    if (SGMII_PORT < 1 || SGMII_PORT > NUM_PORTS) begin : g_bad_sgmii
        $error("pwi_wake_irq: SGMII_PORT out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // True when the address falls in the page of port index idx
    function automatic logic port_hit(input logic [`PWI_ADDR_W-1:0] addr,
                                      input int idx);
        port_hit = (addr[`PWI_PORT_HI:`PWI_PORT_LO] ==
                    4'(idx + 1));
    endfunction

    // Offset part of an address
    function automatic logic [`PWI_OFS_HI:0] ofs_of(
        input logic [`PWI_ADDR_W-1:0] addr);
        ofs_of = addr[`PWI_OFS_HI:`PWI_OFS_LO];
    endfunction

    // Wake bits that exist on a port; the rest read zero and ignore writes
    function automatic pwi_byte_t wake_bits(input int idx);
        pwi_byte_t b;
        b = `PWI_RST_BYTE;
        b[`PWI_WAKE_MAGIC] = 1'b1;
        b[`PWI_WAKE_LINK] = PHY_PORTS[idx];
        b[`PWI_WAKE_ENERGY] = PHY_PORTS[idx];
        wake_bits = b;
    endfunction

    // Interrupt bits that exist on a port, same layout in status and mask
    function automatic pwi_byte_t irq_bits(input int idx);
        pwi_byte_t b;
        b = `PWI_RST_BYTE;
        b[`PWI_IRQ_ACL] = 1'b1;
        b[`PWI_IRQ_PHY] = PHY_PORTS[idx];
        b[`PWI_IRQ_PTP] = PHY_PORTS[idx];
        b[`PWI_IRQ_SGMII] = ((idx + 1) == SGMII_PORT);
        irq_bits = b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    pwi_byte_t              wake_evt_reg  [NUM_PORTS];
    pwi_byte_t              wake_en_reg   [NUM_PORTS];
    pwi_byte_t              irq_stat_reg  [NUM_PORTS];
    pwi_byte_t              irq_mask_reg  [NUM_PORTS];
    pwi_byte_t              rdata_reg;
    pwi_byte_t              rdata_next;
    logic                   power_event_reg;
    logic                   power_event_next;
    logic                   irq_reg;
    logic                   irq_next;
    logic [NUM_PORTS-1:0]   magic_hit;
    logic [NUM_PORTS-1:0]   wr_evt;
    logic [NUM_PORTS-1:0]   wr_en;
    logic [NUM_PORTS-1:0]   wr_stat;
    logic [NUM_PORTS-1:0]   wr_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Magic packet detection, one comparator per port

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_match
        pwi_mac_match u_match (
            .clock_i       (clock_i),
            .rst_i         (rst_i),
            .frame_valid_i (port_i[p].frame_valid),
            .dest_addr_i   (port_i[p].dest_addr),
            .switch_mac_i  (switch_mac_i),
            .match_o       (magic_hit[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write decode

    // One strobe per register and port; unmapped writes fall through
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            wr_evt[p]  = bus_i.wr && port_hit(bus_i.addr, p) &&
                         (ofs_of(bus_i.addr) == `PWI_OFS_WAKE_EVT);
            wr_en[p]   = bus_i.wr && port_hit(bus_i.addr, p) &&
                         (ofs_of(bus_i.addr) == `PWI_OFS_WAKE_EN);
            wr_stat[p] = bus_i.wr && port_hit(bus_i.addr, p) &&
                         (ofs_of(bus_i.addr) == `PWI_OFS_IRQ_STAT);
            wr_mask[p] = bus_i.wr && port_hit(bus_i.addr, p) &&
                         (ofs_of(bus_i.addr) == `PWI_OFS_IRQ_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake enable registers

    // Only existing bits store; MAC ports keep link and energy at zero
    always_ff @(posedge clock_i) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (rst_i) begin
                wake_en_reg[p] <= `PWI_RST_BYTE;
            end else if (wr_en[p]) begin
                wake_en_reg[p] <= bus_i.wdata & wake_bits(p);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake event flags

    // Sticky flags, write one to clear; a new detection beats the clear
    always_ff @(posedge clock_i) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (rst_i) begin
                wake_evt_reg[p] <= `PWI_RST_BYTE;
            end else begin
                wake_evt_reg[p] <= ((wake_evt_reg[p] &
                                     ~(wr_evt[p] ? bus_i.wdata : `PWI_RST_BYTE)) |
                                    {5'h00,
                                     magic_hit[p],
                                     port_i[p].link_up,
                                     port_i[p].energy}) &
                                   wake_bits(p);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt mask registers

    // Zero enables a source, so the reset value leaves all sources live
    always_ff @(posedge clock_i) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (rst_i) begin
                irq_mask_reg[p] <= `PWI_RST_BYTE;
            end else if (wr_mask[p]) begin
                irq_mask_reg[p] <= bus_i.wdata & irq_bits(p);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status registers

    // ACL and SGMII bits are sticky; PTP and PHY follow their summaries.
    // Reads never clear anything, so polling software cannot lose an event.
    always_ff @(posedge clock_i) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (rst_i) begin
                irq_stat_reg[p] <= `PWI_RST_BYTE;
            end else begin
                // ACL clears on a change of its mask bit; a set wins
                if (port_i[p].acl_irq) begin
                    irq_stat_reg[p][`PWI_IRQ_ACL] <= 1'b1;
                end else if (wr_mask[p] &&
                             (bus_i.wdata[`PWI_IRQ_ACL] !=
                              irq_mask_reg[p][`PWI_IRQ_ACL])) begin
                    irq_stat_reg[p][`PWI_IRQ_ACL] <= 1'b0;
                end
                // Level summaries, forced to zero on MAC ports
                irq_stat_reg[p][`PWI_IRQ_PHY] <= port_i[p].phy_irq &&
                                                 PHY_PORTS[p];
                irq_stat_reg[p][`PWI_IRQ_PTP] <= port_i[p].ptp_irq &&
                                                 PHY_PORTS[p];
                // Autoneg done: sticky, write one to clear, set wins
                if (port_i[p].sgmii_an_done && ((p + 1) == SGMII_PORT)) begin
                    irq_stat_reg[p][`PWI_IRQ_SGMII] <= 1'b1;
                end else if (wr_stat[p] && bus_i.wdata[`PWI_IRQ_SGMII]) begin
                    irq_stat_reg[p][`PWI_IRQ_SGMII] <= 1'b0;
                end
                // Reserved bits stay zero
                irq_stat_reg[p][`PWI_DATA_W-1:`PWI_IRQ_SGMII+1] <= 4'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output summaries

    // Registered so the pins never glitch while flags settle
    always_comb begin
        power_event_next = 1'b0;
        irq_next = 1'b0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (|(wake_evt_reg[p] & wake_en_reg[p])) begin
                power_event_next = 1'b1;
            end
            if (|(irq_stat_reg[p] & ~irq_mask_reg[p] & irq_bits(p))) begin
                irq_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            power_event_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            power_event_reg <= power_event_next;
            irq_reg <= irq_next;
        end
    end

    assign power_event_output_o = power_event_reg;
    assign irq_o = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    // Unmapped addresses read zero; data stand one cycle after the strobe
    always_comb begin
        rdata_next = `PWI_RST_BYTE;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (port_hit(bus_i.addr, p)) begin
                unique case (ofs_of(bus_i.addr))
                    `PWI_OFS_WAKE_EVT: begin
                        rdata_next = wake_evt_reg[p];
                    end
                    `PWI_OFS_WAKE_EN: begin
                        rdata_next = wake_en_reg[p];
                    end
                    `PWI_OFS_IRQ_STAT: begin
                        rdata_next = irq_stat_reg[p];
                    end
                    `PWI_OFS_IRQ_MASK: begin
                        rdata_next = irq_mask_reg[p];
                    end
                    default: begin
                        rdata_next = `PWI_RST_BYTE;
                    end
                endcase
            end
        end
    end

    // Data held only in the cycle after a read strobe
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_reg <= `PWI_RST_BYTE;
        end else if (bus_i.rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= `PWI_RST_BYTE;
        end
    end

    assign rdata_o = rdata_reg;

endmodule // pwi_wake_irq

// ==== pwi_defines.svh ====
// Constants for the port wake and interrupt summary block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef PWI_DEFINES_SVH
`define PWI_DEFINES_SVH

// Bus widths
`define PWI_ADDR_W        16
`define PWI_DATA_W        8
`define PWI_MAC_W         48

// Address layout: port number in the top nibble, offset below
`define PWI_PORT_HI       15
`define PWI_PORT_LO       12
`define PWI_OFS_HI        11
`define PWI_OFS_LO        0

// Register offsets inside a port page
`define PWI_OFS_WAKE_EVT  12'h013
`define PWI_OFS_WAKE_EN   12'h017
`define PWI_OFS_IRQ_STAT  12'h01B
`define PWI_OFS_IRQ_MASK  12'h01F

// Reset values
`define PWI_RST_BYTE      8'h00
`define PWI_RST_MAC       48'h0000_0000_0000

// Wake event and wake enable fields
`define PWI_WAKE_MAGIC    2
`define PWI_WAKE_LINK     1
`define PWI_WAKE_ENERGY   0

// Interrupt status and mask fields
`define PWI_IRQ_SGMII     3
`define PWI_IRQ_PTP       2
`define PWI_IRQ_PHY       1
`define PWI_IRQ_ACL       0

// Port numbering defaults
`define PWI_NUM_PORTS     7
`define PWI_PHY_PORTS     7'h1F
`define PWI_SGMII_PORT    7
`define PWI_MAX_PORTS     15

`endif

// ==== pwi_pkg.sv ====
// Types shared by the port wake and interrupt summary block.
// Assumes pwi_defines.svh is on the include path.
`include "pwi_defines.svh"

package pwi_pkg;

    // One register bus request
    typedef struct packed {
        logic [`PWI_ADDR_W-1:0] addr;
        logic [`PWI_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } pwi_bus_s;

    // Everything one port reports to this block
    typedef struct packed {
        logic                  frame_valid;   // Pulse: destination address valid
        logic [`PWI_MAC_W-1:0] dest_addr;
        logic                  link_up;       // Pulse
        logic                  energy;        // Pulse
        logic                  sgmii_an_done; // Pulse
        logic                  ptp_irq;       // Level summary
        logic                  phy_irq;       // Level summary
        logic                  acl_irq;       // Pulse
    } pwi_port_in_s;

    typedef logic [`PWI_DATA_W-1:0] pwi_byte_t;

endpackage

// ==== pwi_mac_match.sv ====
// Destination address comparator for magic packet detection.
// Assumes frame_valid_i is a one-cycle pulse beside a stable address.
`timescale 1ns/1ns
`include "pwi_defines.svh"

module pwi_mac_match (
    input  wire logic                  clock_i,
    input  wire logic                  rst_i,
    input  wire logic                  frame_valid_i,
    input  wire logic [`PWI_MAC_W-1:0] dest_addr_i,
    input  wire logic [`PWI_MAC_W-1:0] switch_mac_i,
    output logic                       match_o
);

    logic match_reg;

    // Registered compare keeps the wide equality off the flag path
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            match_reg <= 1'b0;
        end else begin
            match_reg <= frame_valid_i && (dest_addr_i == switch_mac_i);
        end
    end

    assign match_o = match_reg;

endmodule // pwi_mac_match

// ==== pwi_wake_irq_chk.sv ====
// Concurrent checks for the port wake and interrupt summary block.
// Assumes it is bound to pwi_wake_irq and sees only that module's ports.
`timescale 1ns/1ns
`include "pwi_defines.svh"

module pwi_wake_irq_chk #(
    parameter int NUM_PORTS = `PWI_NUM_PORTS
) (
    input wire logic                                  clock_i,
    input wire logic                                  rst_i,
    input wire pwi_pkg::pwi_bus_s                     bus_i,
    input wire pwi_pkg::pwi_byte_t                    rdata_o,
    input wire logic [`PWI_MAC_W-1:0]                 switch_mac_i,
    input wire pwi_pkg::pwi_port_in_s [NUM_PORTS-1:0] port_i,
    input wire logic                                  power_event_output_o,
    input wire logic                                  irq_o
);
    import pwi_pkg::*;

    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////
    // Shadows of port 1 enables and ACL mask, rebuilt from the bus writes
    logic [2:0] en1_reg;
    logic       acl_m_reg;
    logic       wen1;
    logic       wmk1;
    logic       rd_mac;
    assign wen1   = bus_i.wr && (bus_i.addr == 16'h1017);
    assign wmk1   = bus_i.wr && (bus_i.addr == 16'h101f);
    assign rd_mac = bus_i.rd && (bus_i.addr[15:12] > 4'h5); // Ports 6 and 7 have no PHY

    // Same update edge as the design, so antecedents see the live setting
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            en1_reg   <= 3'h0;
            acl_m_reg <= 1'b0;
        end else begin
            if (wen1) en1_reg <= bus_i.wdata[2:0];
            if (wmk1) acl_m_reg <= bus_i.wdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event to output latency; a same-cycle setting write would change the outcome
    AST_ACL_IRQ: assert property (port_i[0].acl_irq && !acl_m_reg && !wmk1 |-> ##2 irq_o)
        else $error("ACL event did not raise irq");
    AST_LINK_PEO: assert property (port_i[0].link_up && en1_reg[1] && !wen1
        |-> ##2 power_event_output_o) else $error("link up did not raise power event");
    AST_ENERGY_PEO: assert property (port_i[0].energy && en1_reg[0] && !wen1
        |-> ##2 power_event_output_o) else $error("energy did not raise power event");
    AST_MAGIC_PEO: assert property ((port_i[0].frame_valid && en1_reg[2] && !wen1
        && port_i[0].dest_addr == switch_mac_i) ##1 !wen1 |-> ##2 power_event_output_o)
        else $error("magic packet did not raise power event");

    // Bits that do not exist read back as zero
    AST_STAT_RSVD: assert property (bus_i.rd && bus_i.addr[11:0] inside {12'h01b, 12'h01f}
        |=> rdata_o[7:4] == 4'h0) else $error("status or mask reserved bits not zero");
    AST_WAKE_RSVD: assert property (bus_i.rd && bus_i.addr[11:0] inside {12'h013, 12'h017}
        |=> rdata_o[7:3] == 5'h00) else $error("wake reserved bits not zero");
    AST_MAC_WAKE: assert property (rd_mac && bus_i.addr[11:0] inside {12'h013, 12'h017}
        |=> rdata_o[1:0] == 2'h0) else $error("link or energy wake on MAC port");
    AST_MAC_STAT: assert property (rd_mac && bus_i.addr[11:0] inside {12'h01b, 12'h01f}
        |=> rdata_o[2:1] == 2'h0) else $error("PTP or PHY bit on MAC port");
    AST_SGMII_ONLY7: assert property (bus_i.rd && bus_i.addr[15:12] != 4'h7
        && bus_i.addr[11:0] inside {12'h01b, 12'h01f} |=> !rdata_o[3])
        else $error("SGMII bit outside port 7");

    // Main scenarios
    COV_ACL: cover property (port_i[0].acl_irq ##2 irq_o);
    COV_PEO: cover property ($rose(power_event_output_o));
    COV_TOGGLE: cover property (wmk1 && bus_i.wdata[0] != acl_m_reg);

endmodule // pwi_wake_irq_chk

bind pwi_wake_irq pwi_wake_irq_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (
    .clock_i(clock_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .switch_mac_i(switch_mac_i), .port_i(port_i),
    .power_event_output_o(power_event_output_o), .irq_o(irq_o));

// ==== pwi_wake_irq_test.sv ====
// Self-checking bench for the port wake and interrupt summary block.
// Assumes the checker file is compiled beside the design; one core clock.
`timescale 1ns/1ns
`include "pwi_defines.svh"

module pwi_wake_irq_test;
    import pwi_pkg::*;

    logic               clock_i    = 1'b0;
    logic               rst_i      = 1'b1;
    pwi_bus_s           bus_v      = '0;
    pwi_byte_t          rdata_o;
    logic [47:0]        mac_v      = 48'h0000_0000_0000;
    pwi_port_in_s [6:0] port_v     = '0;
    logic               pe_o;
    logic               irq_o;
    logic [1:0]         lv [1:7];
    int                 num_errors = 0;
    int                 n_checks   = 0;
    int                 p;
    int                 k;
    pwi_byte_t          d;

    pwi_wake_irq u_dut (.clock_i(clock_i), .rst_i(rst_i), .bus_i(bus_v), .rdata_o(rdata_o),
        .switch_mac_i(mac_v), .port_i(port_v), .power_event_output_o(pe_o), .irq_o(irq_o));

    // Free-running 100 MHz clock
    initial forever #5 clock_i = ~clock_i;

    ////////////////////////////////////////////////////////////////////////////
    // Expected bit sets per port: PHY ports 1-5, SGMII only on port 7
    function automatic pwi_byte_t en_bits(int p);
        return (p <= 5) ? 8'h07 : 8'h04;
    endfunction
    function automatic pwi_byte_t mk_bits(int p);
        return ((p <= 5) ? 8'h07 : 8'h01) | ((p == 7) ? 8'h08 : 8'h00);
    endfunction

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input pwi_byte_t g, input pwi_byte_t e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // Bounded wait on irq_o (s=1) or the power event (s=0); a miss ends the run
    task automatic wait_out(input logic s, input logic v);
        int i;
        for (i = 0; i < 8 && (s ? irq_o : pe_o) !== v; i++) begin
            @(posedge clock_i);
            #1;
        end
        chk({7'h00, s ? irq_o : pe_o}, {7'h00, v});
        if ((s ? irq_o : pe_o) !== v) end_of_test();
    endtask

    // One-cycle strobes; read data is taken in the single cycle after the strobe
    task automatic wr(input int p, input logic [11:0] o, input pwi_byte_t v);
        @(posedge clock_i);
        bus_v <= '{addr: {p[3:0], o}, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        bus_v.wr <= 1'b0;
    endtask
    task automatic rc(input int p, input logic [11:0] o, input pwi_byte_t e);
        @(posedge clock_i);
        bus_v <= '{addr: {p[3:0], o}, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        bus_v.rd <= 1'b0;
        #1 chk(rdata_o, e);
    endtask

    // One-cycle event: 0 energy, 1 link, 2 frame, 3 ACL, 4 SGMII done
    task automatic pulse(input int p, input int k);
        pwi_port_in_s s;
        s = '0;
        case (k)
            0: s.energy = 1'b1;
            1: s.link_up = 1'b1;
            2: s.frame_valid = 1'b1;
            3: s.acl_irq = 1'b1;
            default: s.sgmii_an_done = 1'b1;
        endcase
        @(posedge clock_i);
        port_v[p-1] <= port_v[p-1] | s;
        @(posedge clock_i);
        port_v[p-1] <= port_v[p-1] & ~s;
        #1; // Outputs are looked at only once settled, never on the launch edge
    endtask

    task automatic idle4;
        repeat (4) @(posedge clock_i);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h7b1b_2f4d));
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        for (p = 1; p <= 7; p++) for (k = 0; k < 4; k++) rc(p, 12'h013 + 12'(4 * k), 8'h00);
        $display("end of test 1");
        // Random and all-ones writes; missing bits must drop out
        for (p = 1; p <= 7; p++) for (k = 0; k < 2; k++) begin
            d = k ? 8'hff : 8'($urandom());
            wr(p, 12'h017, d);
            rc(p, 12'h017, d & en_bits(p));
            wr(p, 12'h01f, d);
            rc(p, 12'h01f, d & mk_bits(p));
            wr(p, 12'h01f, 8'h00);
            wr(p, 12'h017, 8'h00);
        end
        wr(1, 12'h018, 8'hff);
        rc(1, 12'h018, 8'h00);
        $display("end of test 2");
        // ACL on a PHY port and on the SGMII MAC port
        for (k = 0; k < 2; k++) begin
            p = k ? 7 : 1;
            pulse(p, 3);
            wait_out(1'b1, 1'b1);
            rc(p, 12'h01b, 8'h01);
            rc(p, 12'h01b, 8'h01);
            wr(p, 12'h01f, 8'h01);
            rc(p, 12'h01b, 8'h00);
            wait_out(1'b1, 1'b0);
            pulse(p, 3);
            idle4();
            chk({7'h00, irq_o}, 8'h00);
            wr(p, 12'h01f, 8'h01);
            rc(p, 12'h01b, 8'h01);
            wr(p, 12'h01f, 8'h00);
            rc(p, 12'h01b, 8'h00);
        end
        $display("end of test 3");
        // Random PTP and PHY summary levels
        for (p = 1; p <= 7; p++) begin
            lv[p] = 2'($urandom());
            port_v[p-1].ptp_irq <= lv[p][1];
            port_v[p-1].phy_irq <= lv[p][0];
        end
        idle4();
        for (p = 1; p <= 7; p++) rc(p, 12'h01b, (p <= 5) ? {5'h00, lv[p], 1'b0} : 8'h00);
        for (p = 1; p <= 7; p++) port_v[p-1].ptp_irq <= 1'b0;
        for (p = 1; p <= 7; p++) port_v[p-1].phy_irq <= (p == 3);
        wait_out(1'b1, 1'b1);
        wr(3, 12'h01f, 8'h02);
        wait_out(1'b1, 1'b0);
        port_v[2].phy_irq <= 1'b0;
        port_v[5].ptp_irq <= 1'b1;
        wr(3, 12'h01f, 8'h00);
        idle4();
        chk({7'h00, irq_o}, 8'h00);
        port_v[5].ptp_irq <= 1'b0;
        $display("end of test 4");
        pulse(7, 4);
        pulse(1, 4);
        rc(7, 12'h01b, 8'h08);
        rc(1, 12'h01b, 8'h00);
        wait_out(1'b1, 1'b1);
        wr(7, 12'h01b, 8'h08);
        rc(7, 12'h01b, 8'h00);
        wait_out(1'b1, 1'b0);
        $display("end of test 5");
        // Wake sources, enabled and not, on a PHY port and a MAC port
        mac_v <= {16'($urandom()), $urandom()};
        @(posedge clock_i);
        port_v[0].dest_addr <= mac_v;
        port_v[5].dest_addr <= mac_v;
        for (k = 0; k < 3; k++) begin
            wr(1, 12'h017, 8'h01 << k);
            pulse(1, k);
            wait_out(1'b0, 1'b1);
            rc(1, 12'h013, 8'h01 << k);
            wr(1, 12'h013, 8'h01 << k);
            wait_out(1'b0, 1'b0);
            wr(1, 12'h017, 8'h00);
            pulse(1, k);
            idle4();
            chk({7'h00, pe_o}, 8'h00);
            rc(1, 12'h013, 8'h01 << k);
            wr(1, 12'h013, 8'h07);
            wr(6, 12'h017, 8'h07);
            pulse(6, k);
            rc(6, 12'h013, (k == 2) ? 8'h04 : 8'h00);
            wr(6, 12'h013, 8'h07);
            wr(6, 12'h017, 8'h00);
        end
        port_v[0].dest_addr <= ~mac_v;
        pulse(1, 2);
        idle4();
        rc(1, 12'h013, 8'h00);
        $display("end of test 6");
        end_of_test();
    end

endmodule // pwi_wake_irq_test
